// ---- common/charger_pkg.sv ----
package charger_pkg;

	// Power figures are kept in half-watt units
	localparam int              PWR_W        = 8;
	localparam logic [PWR_W-1:0] PWR_CUR_MIN  = 8'h0f; // 5 V at 1.5 A
	localparam logic [PWR_W-1:0] PWR_CUR_HI   = 8'h1e; // 5 V at 3 A
	localparam logic [PWR_W-1:0] PWR_LEGACY   = 8'h05; // 5 V at 500 mA
	localparam logic [PWR_W-1:0] PWR_PD_START = 8'h1e; // 15 W first PD target after attach
	localparam logic [PWR_W-1:0] PWR_PD_MAX   = 8'h46; // 35 W port rating
	localparam logic [PWR_W-1:0] PWR_BUDGET   = 8'h78; // 60 W shared pool
	localparam logic [PWR_W-1:0] PWR_ZERO     = 8'h00;

	// Reset values of the control state
	localparam logic RST_VBUS   = 1'b0;
	localparam logic RST_PULSE  = 1'b0;
	localparam logic RST_LEGACY = 1'b1;

	// Current advertisement levels on the configuration pin
	typedef enum logic [1:0] {
		ADV_DEFAULT,
		ADV_1A5,
		ADV_3A0
	} adv_type;

	// Allocation scanner states
	typedef enum logic [1:0] {
		ST_SCAN,
		ST_RECLAIM,
		ST_ASSURED
	} scan_state_type;

endpackage : charger_pkg

// ---- rtl/sync2.sv ----
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// Two stages; only the second stage is read by the design
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : sync2

`default_nettype wire

// ---- rtl/port_grant.sv ----
`timescale 1ns/1ps
`default_nettype none

module port_grant
	import charger_pkg::*;
(
	input  wire logic [PWR_W-1:0] cur_alloc,
	input  wire logic [PWR_W-1:0] target,
	input  wire logic [PWR_W-1:0] pool_free,
	input  wire logic             step_only,
	output var  logic [PWR_W-1:0] new_alloc,
	output var  logic             granted
);

	logic [PWR_W:0] reach;

	// Raise toward the target as far as the pool allows; a current-only
	// port has discrete levels, so it moves only when the whole step fits
	always_comb begin
		reach = {1'b0, cur_alloc} + {1'b0, pool_free};
		if (cur_alloc >= target) begin
			new_alloc = cur_alloc;
		end else if (reach >= {1'b0, target}) begin
			new_alloc = target;
		end else if (step_only) begin
			new_alloc = cur_alloc;
		end else begin
			new_alloc = reach[PWR_W-1:0];
		end
		granted = (new_alloc != cur_alloc);
	end

endmodule : port_grant

`default_nettype wire

// ---- rtl/charger_budget.sv ----
// Functional notes
// [RULE1] Every reversible port always keeps at least 5 V at 1.5 A reserved.
// [RULE2] Every legacy Standard-A port always keeps at least 5 V at 500 mA.
// [RULE3] Legacy ports form their own group, never part of the shared pool.
// [RULE4] Assured group ports ignore other ports' attach state and load.
// [RULE5] Assured independence may break only for protective action after a fault.
// [RULE6] Shared ports have identical minimum and maximum and draw equally.
// [RULE7] Shared port offers minimum first, raises toward maximum after attach.
// [RULE8] Newly attached ports are raised in turn until the pool is used up.
// [RULE9] PD ports start at a reduced offer, raise with new capabilities on demand.
// [RULE10] A sink wanting more sends a request with capability mismatch set.
// [RULE11] Unconnected shared ports all advertise the same, capped by remaining pool.
// [RULE12] Rebalancing may reclaim power by re-advertising reduced capabilities.
// [RULE13] Rebalancing may reclaim power by sending GotoMin to contracted ports.
// [RULE14] Rebalancing follows system policy, only from ports allowed to yield.
// [RULE15] Charging works fully regardless of any data bus state.
// [RULE16] Hub upstream port may share the pool with a different rating.
// [RULE17] Each group applies assured or shared allocation independently.
// [RULE18] Offers are re-sent whenever available resources change.
// [RULE19] Bus power only after sink attach, removed on detach.
// [RULE20] Detach returns the port's allocation to the pool, offers recomputed.
`timescale 1ns/1ps
`default_nettype none

module charger_budget
	import charger_pkg::*;
#(
	parameter int              NUM_PORTS   = 2,
	parameter int              NUM_LEGACY  = 1,
	parameter logic [PWR_W-1:0] PORT_MAX    = PWR_PD_MAX,
	parameter logic [PWR_W-1:0] BUDGET      = PWR_BUDGET,
	parameter bit              HUB_UFP_EN  = 1'b0,
	parameter int              HUB_UFP_IDX = 0,
	parameter logic [PWR_W-1:0] HUB_UFP_MAX = PWR_PD_MAX
) (
	input  wire logic                            clk_sys,
	input  wire logic                            rst,
	input  wire logic                            group_shared,
	input  wire logic [NUM_PORTS-1:0]            sink_attached,
	input  wire logic [NUM_PORTS-1:0]            port_fault,
	input  wire logic [NUM_PORTS-1:0]            pd_capable,
	input  wire logic [NUM_PORTS-1:0]            cap_mismatch,
	input  wire logic [NUM_PORTS-1:0]            yield_ok,
	input  wire logic                            rebalance_en,
	input  wire logic                            gotomin_sel,
	input  wire logic [NUM_LEGACY-1:0]           legacy_fault,
	output var  logic [NUM_PORTS-1:0]            vbus_en,
	output var  adv_type [NUM_PORTS-1:0]         adv_level,
	output var  logic [NUM_PORTS-1:0][PWR_W-1:0] port_offer,
	output var  logic [NUM_PORTS-1:0]            caps_send,
	output var  logic [NUM_PORTS-1:0]            gotomin_send,
	output var  logic [PWR_W-1:0]                idle_offer,
	output var  logic [PWR_W-1:0]                pool_free,
	output var  logic [NUM_LEGACY-1:0]           legacy_vbus_en
);

	// Pointer width; a single port still needs one bit of index
	localparam int IDX_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

	// Refuse configurations the allocator cannot honour
	initial begin
		if (NUM_PORTS < 1 || NUM_LEGACY < 1 || NUM_PORTS > 15)
			$error("charger_budget: port counts out of range");
		if (PORT_MAX < PWR_CUR_MIN || HUB_UFP_MAX < PWR_CUR_MIN)
			$error("charger_budget: port rating below the guaranteed minimum");
		if (int'(BUDGET) < NUM_PORTS * int'(PWR_CUR_MIN))
			$error("charger_budget: pool cannot reserve the minimum on every port");
		if (HUB_UFP_EN && HUB_UFP_IDX >= NUM_PORTS)
			$error("charger_budget: upstream port index out of range");
	end

	// Whole allocator state, registered in one place
	typedef struct packed {
		scan_state_type                  st;
		logic [IDX_W-1:0]                idx;
		logic [NUM_PORTS-1:0]            att;
		logic [NUM_PORTS-1:0]            vbus;
		logic [NUM_PORTS-1:0]            fault;
		logic [NUM_PORTS-1:0]            caps;
		logic [NUM_PORTS-1:0]            gotomin;
		logic [NUM_PORTS-1:0][PWR_W-1:0] alloc;
		logic [NUM_PORTS-1:0][PWR_W-1:0] target;
		adv_type [NUM_PORTS-1:0]         adv;
		logic [PWR_W-1:0]                idle;
		logic [PWR_W-1:0]                free;
		logic [NUM_LEGACY-1:0]           legacy_on;
	} state_type;

	state_type state_reg;
	state_type state_next;

	// Rating of a port; only the hub upstream port may differ
	function automatic logic [PWR_W-1:0] port_max(input int i);
		if (HUB_UFP_EN && i == HUB_UFP_IDX)
			return HUB_UFP_MAX; // see [RULE16]
		return PORT_MAX; // see [RULE6]
	endfunction : port_max

	// Ceiling of a port that only signals current on its pin
	function automatic logic [PWR_W-1:0] cur_max(input int i);
		logic [PWR_W-1:0] m;
		m = port_max(i);
		return (m < PWR_CUR_HI) ? m : PWR_CUR_HI;
	endfunction : cur_max

	// Current level shown for a given allocation
	// Anything below the 3 A step shows 1.5 A, never the default level
	function automatic adv_type adv_of(input logic [PWR_W-1:0] a);
		return (a >= PWR_CUR_HI) ? ADV_3A0 : ADV_1A5;
	endfunction : adv_of

	// Pins from the connector side are synchronised before use
	logic                 shared_sync;
	logic [NUM_PORTS-1:0] attach_sync;
	logic [NUM_PORTS-1:0] fault_sync;
	logic [NUM_LEGACY-1:0] legacy_fault_sync;

	sync2 #(
		.WIDTH(1 + 2 * NUM_PORTS + NUM_LEGACY)
	) u_pin_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in ({group_shared, sink_attached, port_fault, legacy_fault}),
		.sync_out ({shared_sync, attach_sync, fault_sync, legacy_fault_sync})
	);

	// Pool left after every port's allocation, including idle reserves
	// Saturates at zero because assured mode may promise more than the pool
	// Four spare bits hold the sum of up to fifteen full ports
	logic [PWR_W+3:0] used_sum;
	logic [PWR_W-1:0] free_now;

	always_comb begin
		used_sum = '0;
		for (int i = 0; i < NUM_PORTS; i++) begin
			used_sum = used_sum + {4'h0, state_reg.alloc[i]};
		end
		if (used_sum >= {4'h0, BUDGET}) begin
			free_now = PWR_ZERO;
		end else begin
			free_now = BUDGET - used_sum[PWR_W-1:0];
		end
	end

	// Grant calculation for the port under the scan pointer
	logic [PWR_W-1:0] scan_alloc;
	logic [PWR_W-1:0] scan_target;
	logic             scan_step;
	logic [PWR_W-1:0] scan_new;
	logic             scan_granted;

	assign scan_alloc  = state_reg.alloc[state_reg.idx];
	assign scan_target = state_reg.target[state_reg.idx];
	assign scan_step   = ~pd_capable[state_reg.idx];

	port_grant u_grant (
		.cur_alloc (scan_alloc),
		.target    (scan_target),
		.pool_free (free_now),
		.step_only (scan_step),
		.new_alloc (scan_new),
		.granted   (scan_granted)
	);

	// Donor search: first attached port that policy lets give power back
	// Lowest index wins so the choice repeats for the same attach order
	logic [NUM_PORTS-1:0] donor_mask;
	logic                 donor_found;
	logic [IDX_W-1:0]     donor_idx;

	always_comb begin
		donor_found = 1'b0;
		donor_idx   = '0;
		for (int i = 0; i < NUM_PORTS; i++) begin
			donor_mask[i] = state_reg.att[i] & yield_ok[i] & ~state_reg.fault[i]
				& (state_reg.alloc[i] > PWR_CUR_MIN)
				& (i != int'(state_reg.idx)); // see [RULE14]
		end
		for (int i = NUM_PORTS - 1; i >= 0; i--) begin
			if (donor_mask[i]) begin
				donor_found = 1'b1;
				donor_idx   = IDX_W'(i);
			end
		end
	end

	logic [PWR_W-1:0] idle_cap;

	// Next state of the whole allocator
	always_comb begin
		state_next         = state_reg;
		state_next.caps    = '0;
		state_next.gotomin = '0;
		state_next.att     = attach_sync;
		state_next.free    = free_now;

		// Attach and detach bookkeeping; no data bus term anywhere here
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (attach_sync[i] && !state_reg.att[i]) begin
				state_next.vbus[i]   = ~state_reg.fault[i]; // see [RULE19] [RULE15]
				state_next.alloc[i]  = PWR_CUR_MIN; // see [RULE7]
				state_next.target[i] = pd_capable[i]
					? ((port_max(i) < PWR_PD_START) ? port_max(i) : PWR_PD_START)
					: cur_max(i); // see [RULE9]
				state_next.caps[i]   = pd_capable[i];
			end else if (!attach_sync[i] && state_reg.att[i]) begin
				state_next.vbus[i]   = RST_VBUS; // see [RULE19]
				state_next.fault[i]  = 1'b0;
				state_next.alloc[i]  = PWR_CUR_MIN; // see [RULE20]
				state_next.target[i] = PWR_CUR_MIN;
			end
			// A mismatch request asks for the full rating
			if (state_reg.att[i] && pd_capable[i] && cap_mismatch[i]) begin
				state_next.target[i] = port_max(i); // see [RULE10]
			end
			// Protective shutdown latches until the sink leaves; a fault that
			// outlasts the sink must not lock out the next attach
			if (fault_sync[i] && attach_sync[i]) begin
				state_next.fault[i] = 1'b1; // see [RULE5]
				state_next.vbus[i]  = 1'b0;
			end
		end

		case (state_reg.st)
			ST_ASSURED: begin
				// Every PD port owns its full rating, a current-only port its 3 A ceiling, whatever the others do
				for (int i = 0; i < NUM_PORTS; i++) begin
					state_next.alloc[i]  = pd_capable[i] ? port_max(i) : cur_max(i); // see [RULE4]
					state_next.target[i] = state_next.alloc[i];
				end
				if (shared_sync) begin
					state_next.st = ST_SCAN; // see [RULE17]
					for (int i = 0; i < NUM_PORTS; i++) begin
						state_next.alloc[i]  = PWR_CUR_MIN;
						state_next.target[i] = PWR_CUR_MIN;
					end
				end
			end
			ST_SCAN: begin
				if (!shared_sync) begin
					state_next.st = ST_ASSURED; // see [RULE17]
				end else if (state_reg.att[state_reg.idx] && !state_reg.fault[state_reg.idx]
					&& scan_alloc < scan_target) begin
					if (scan_granted) begin
						// Raise this port, then move on to the next in turn
						state_next.alloc[state_reg.idx] = scan_new; // see [RULE8]
						state_next.idx = (int'(state_reg.idx) == NUM_PORTS - 1)
							? '0 : state_reg.idx + 1'b1;
					end else if (rebalance_en && donor_found) begin
						// Reclaim from the donor, grant on the next visit
						state_next.alloc[donor_idx]  = PWR_CUR_MIN; // see [RULE12]
						state_next.target[donor_idx] = PWR_CUR_MIN;
						if (pd_capable[donor_idx] && gotomin_sel) begin
							state_next.gotomin[donor_idx] = 1'b1; // see [RULE13]
						end
						state_next.st = ST_RECLAIM;
					end else begin
						// Pool too short and no donor: this port waits while the scan moves on
						state_next.idx = (int'(state_reg.idx) == NUM_PORTS - 1)
							? '0 : state_reg.idx + 1'b1; // see [RULE8]
					end
				end else begin
					state_next.idx = (int'(state_reg.idx) == NUM_PORTS - 1)
						? '0 : state_reg.idx + 1'b1;
				end
			end
			ST_RECLAIM: begin
				// One cycle so the pool total reflects the reclaimed power;
				// free_now is built from the registered allocations, so the requester sees the reclaim either way
				state_next.st = shared_sync ? ST_SCAN : ST_ASSURED;
			end
			default: begin
				state_next.st = ST_ASSURED;
			end
		endcase

		// New capabilities whenever an attached PD port's share changes, unless it is sent GotoMin
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (state_next.att[i] && pd_capable[i] && !state_next.gotomin[i]
				&& state_next.alloc[i] != state_reg.alloc[i]) begin
				state_next.caps[i] = 1'b1; // see [RULE18]
			end
		end

		// Offer that every unconnected shared port shows alike
		// Recomputed every cycle from the registered allocations, so a detach widens it two cycles after it is seen
		idle_cap = PORT_MAX;
		if (state_next.st != ST_ASSURED) begin
			if ({1'b0, PWR_CUR_MIN} + {1'b0, free_now} < {1'b0, PORT_MAX}) begin
				idle_cap = PWR_CUR_MIN + free_now; // see [RULE11]
			end
		end
		state_next.idle = idle_cap;

		// Pin advertisement follows the allocation; idle shared ports show the minimum, idle assured ports their ceiling
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (!state_next.att[i]) begin
				state_next.adv[i] = (state_next.st == ST_ASSURED)
					? adv_of(cur_max(i)) : ADV_1A5; // see [RULE7] [RULE1]
			end else begin
				state_next.adv[i] = adv_of(state_next.alloc[i]); // see [RULE1]
			end
		end

		// Legacy ports sit outside the pool with a fixed 500 mA reserve
		// Their fault only drops their own power, never a reversible port's
		state_next.legacy_on = ~legacy_fault_sync; // see [RULE2] [RULE3]
	end

	// Single register stage for all allocator state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg.st        <= ST_ASSURED;
			state_reg.idx       <= '0;
			state_reg.att       <= '0;
			state_reg.vbus      <= {NUM_PORTS{RST_VBUS}};
			state_reg.fault     <= '0;
			state_reg.caps      <= {NUM_PORTS{RST_PULSE}};
			state_reg.gotomin   <= {NUM_PORTS{RST_PULSE}};
			state_reg.alloc     <= {NUM_PORTS{PWR_CUR_MIN}};
			state_reg.target    <= {NUM_PORTS{PWR_CUR_MIN}};
			state_reg.adv       <= {NUM_PORTS{ADV_1A5}};
			state_reg.idle      <= PWR_CUR_MIN;
			state_reg.free      <= PWR_ZERO;
			state_reg.legacy_on <= {NUM_LEGACY{RST_LEGACY}};
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from the state register
	// No logic after the register, so every output is glitch free
	assign vbus_en        = state_reg.vbus;
	assign adv_level      = state_reg.adv;
	assign port_offer     = state_reg.alloc;
	assign caps_send      = state_reg.caps;
	assign gotomin_send   = state_reg.gotomin;
	assign idle_offer     = state_reg.idle;
	assign pool_free      = state_reg.free;
	assign legacy_vbus_en = state_reg.legacy_on;

endmodule : charger_budget

`default_nettype wire

// ---- testbench/charger_budget_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module charger_budget_sva
	import charger_pkg::*;
#(
	parameter logic [PWR_W-1:0] PORT_MAX = PWR_PD_MAX,
	parameter logic [PWR_W-1:0] BUDGET   = PWR_BUDGET
) (
	input wire logic                  clk_sys,
	input wire logic                  rst,
	input wire logic                  group_shared,
	input wire logic [1:0]            sink_attached,
	input wire logic [1:0]            port_fault,
	input wire logic [1:0]            pd_capable,
	input wire logic [1:0]            yield_ok,
	input wire logic                  rebalance_en,
	input wire logic                  gotomin_sel,
	input wire logic [0:0]            legacy_fault,
	input wire logic [1:0]            vbus_en,
	input wire adv_type [1:0]         adv_level,
	input wire logic [1:0][PWR_W-1:0] port_offer,
	input wire logic [1:0]            caps_send,
	input wire logic [1:0]            gotomin_send,
	input wire logic [PWR_W-1:0]      idle_offer,
	input wire logic [PWR_W-1:0]      pool_free,
	input wire logic [0:0]            legacy_vbus_en
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_offer_range;
		port_offer[0] >= PWR_CUR_MIN && port_offer[1] >= PWR_CUR_MIN &&
		port_offer[0] <= PORT_MAX && port_offer[1] <= PORT_MAX;
	endproperty
	a_offer_range: assert property (p_offer_range) else $error("offer out of range");
	property p_adv_floor;
		adv_level[0] != ADV_DEFAULT && adv_level[1] != ADV_DEFAULT;
	endproperty
	a_adv_floor: assert property (p_adv_floor) else $error("default advertised");
	property p_legacy;
		$stable(legacy_fault)[*4] |-> legacy_vbus_en == ~legacy_fault;
	endproperty
	a_legacy: assert property (p_legacy) else $error("legacy power wrong");
	property p_detach_off;
		(!sink_attached[0])[*4] |-> !vbus_en[0];
	endproperty
	a_detach_off: assert property (p_detach_off) else $error("power without sink");
	property p_power_on;
		$rose(vbus_en[0]) |-> $past(sink_attached[0], 2);
	endproperty
	a_power_on: assert property (p_power_on) else $error("power before attach");
	property p_fault_off;
		port_fault[0][*4] |-> !vbus_en[0];
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("power kept in fault");
	property p_assured;
		(!group_shared && sink_attached[0] && pd_capable[0] && !port_fault[0])[*6]
			|-> port_offer[0] == PORT_MAX;
	endproperty
	a_assured: assert property (p_assured) else $error("assured offer short");
	// Pool lags the allocations by one cycle
	property p_pool;
		group_shared[*6] |->
			pool_free == PWR_W'(BUDGET - $past(port_offer[0]) - $past(port_offer[1]));
	endproperty
	a_pool: assert property (p_pool) else $error("pool not conserved");
	property p_idle;
		(group_shared && $stable(pool_free))[*6] |-> idle_offer ==
			((PWR_CUR_MIN + pool_free > PORT_MAX) ? PORT_MAX : PWR_CUR_MIN + pool_free);
	endproperty
	a_idle: assert property (p_idle) else $error("idle offer wrong");
	property p_gotomin;
		gotomin_send[0] |-> $past(rebalance_en) && $past(gotomin_sel) && $past(yield_ok[0]);
	endproperty
	a_gotomin: assert property (p_gotomin) else $error("gotomin not allowed");
	property p_raise_caps;
		vbus_en[0] && pd_capable[0] && port_offer[0] > $past(port_offer[0]) |-> caps_send[0];
	endproperty
	a_raise_caps: assert property (p_raise_caps) else $error("raise not sent");

	c_gotomin: cover property (gotomin_send[0]);
	c_caps: cover property (caps_send[1]);
	c_full: cover property (vbus_en[1] && adv_level[1] == ADV_3A0);
endmodule : charger_budget_sva

`default_nettype wire

// ---- testbench/sink_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module sink_model
	import charger_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic [1:0]            caps_send,
	input  wire logic [1:0][PWR_W-1:0] port_offer,
	input  wire logic [1:0][PWR_W-1:0] want,
	input  wire logic [1:0]            slow,
	output var  logic [1:0]            cap_mismatch
);
	logic [1:0] pend;

	// Short offer answered by a mismatch request; slow sinks answer a cycle later
	initial begin
		cap_mismatch = '0;
		pend = '0;
		forever begin
			@(posedge clk_sys);
			#1;
			for (int i = 0; i < 2; i++) begin
				cap_mismatch[i] = pend[i];
				pend[i] = 1'b0;
				if (caps_send[i] === 1'b1 && port_offer[i] < want[i]) begin
					if (slow[i])
						pend[i] = 1'b1;
					else
						cap_mismatch[i] = 1'b1;
				end
			end
		end
	end
endmodule : sink_model

`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import charger_pkg::*;
;
	logic                  clk_sys, rst, group_shared, rebalance_en, gotomin_sel, gm_seen;
	logic [1:0]            sink_attached, port_fault, pd_capable, cap_mismatch, yield_ok;
	logic [1:0]            vbus_en, caps_send, gotomin_send, slow;
	logic [0:0]            legacy_fault, legacy_vbus_en;
	adv_type [1:0]         adv_level;
	logic [1:0][PWR_W-1:0] port_offer, want;
	logic [PWR_W-1:0]      idle_offer, pool_free;
	int                    error_cnt = 0;
	int                    n_checks = 0;

	charger_budget dut (.clk_sys(clk_sys), .rst(rst), .group_shared(group_shared),
		.sink_attached(sink_attached), .port_fault(port_fault), .pd_capable(pd_capable),
		.cap_mismatch(cap_mismatch), .yield_ok(yield_ok), .rebalance_en(rebalance_en),
		.gotomin_sel(gotomin_sel), .legacy_fault(legacy_fault), .vbus_en(vbus_en),
		.adv_level(adv_level), .port_offer(port_offer), .caps_send(caps_send),
		.gotomin_send(gotomin_send), .idle_offer(idle_offer), .pool_free(pool_free),
		.legacy_vbus_en(legacy_vbus_en));
	sink_model sink (.clk_sys(clk_sys), .caps_send(caps_send), .port_offer(port_offer),
		.want(want), .slow(slow), .cap_mismatch(cap_mismatch));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Latch a reclaim pulse so a test need not hit its exact cycle
	always @(posedge clk_sys) gm_seen <= (gm_seen === 1'b1) || (gotomin_send[0] === 1'b1);

	task step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step

	task chk(input bit ok, input string msg);
		n_checks++;
		if (!ok) begin
			error_cnt++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : chk

	// Bounded wait for bus power on one port
	task wait_vbus(input int p);
		for (int k = 0; k < 20 && vbus_en[p] !== 1'b1; k++) step(1);
		chk(vbus_en[p] === 1'b1, "no bus power");
	endtask : wait_vbus

	task results;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	task t_legacy;
		chk(legacy_vbus_en === 1'b1, "legacy off");
		legacy_fault = 1'b1;
		step(4);
		chk(legacy_vbus_en === 1'b0, "legacy kept");
		legacy_fault = 1'b0;
		step(4);
		chk(legacy_vbus_en === 1'b1, "legacy lost");
		$display("done legacy");
	endtask : t_legacy

	task t_assured;
		sink_attached = 2'b01;
		step(2);
		chk(vbus_en[0] === 1'b0, "power too early");
		wait_vbus(0);
		step(2);
		chk(port_offer[0] === PWR_PD_MAX, "assured pd offer");
		sink_attached = 2'b11;
		step(6);
		chk(port_offer[1] === PWR_CUR_HI && adv_level[1] === ADV_3A0, "assured 3 A");
		chk(port_offer[0] === PWR_PD_MAX, "port 0 disturbed");
		sink_attached = 2'b01;
		step(6);
		chk(vbus_en === 2'b01 && port_offer[0] === PWR_PD_MAX, "detach effect");
		sink_attached = 2'b00;
		step(6);
		$display("done assured");
	endtask : t_assured

	task t_shared;
		group_shared = 1'b1;
		pd_capable = 2'b11;
		rebalance_en = 1'b1;
		gotomin_sel = 1'b1;
		yield_ok = 2'b01;
		step(8);
		chk(port_offer === {PWR_CUR_MIN, PWR_CUR_MIN}, "start not minimum");
		chk(idle_offer === PWR_PD_MAX, "idle offer");
		sink_attached = 2'b01;
		wait_vbus(0);
		chk(port_offer[0] === PWR_CUR_MIN && caps_send[0] === 1'b1, "first offer");
		step(30);
		chk(port_offer[0] === PWR_PD_MAX, "no raise on mismatch");
		chk(idle_offer === 8'h32, "remaining offer");
		sink_attached = 2'b11;
		step(40);
		chk(gm_seen === 1'b1, "no reclaim");
		chk(port_offer[1] === PWR_PD_MAX, "late port short");
		sink_attached = 2'b01;
		step(10);
		chk(vbus_en[1] === 1'b0 && port_offer[1] === PWR_CUR_MIN, "detach alloc");
		chk(port_offer[0] === PWR_CUR_MIN, "donor not at minimum");
		chk(pool_free === PWR_W'(PWR_BUDGET - 2 * PWR_CUR_MIN), "pool");
		pd_capable = 2'b01;
		sink_attached = 2'b11;
		wait_vbus(1);
		chk(adv_level[1] === ADV_1A5, "not 1.5 A first");
		step(20);
		chk(adv_level[1] === ADV_3A0, "not raised to 3 A");
		sink_attached = 2'b00;
		step(6);
		$display("done shared");
	endtask : t_shared

	task t_fault;
		sink_attached = 2'b01;
		wait_vbus(0);
		port_fault = 2'b01;
		step(6);
		chk(vbus_en[0] === 1'b0, "power kept in fault");
		sink_attached = 2'b00;
		step(4);
		port_fault = 2'b00;
		step(4);
		sink_attached = 2'b01;
		wait_vbus(0);
		$display("done fault");
	endtask : t_fault

	// Reclaim through reduced capabilities instead of GotoMin
	task t_rebalance;
		gotomin_sel = 1'b0;
		step(30);
		pd_capable = 2'b11;
		sink_attached = 2'b11;
		step(40);
		chk(port_offer[1] === PWR_PD_MAX, "late port not raised");
		chk(port_offer[0] === PWR_W'(PWR_BUDGET - PWR_PD_MAX), "donor not re-offered");
		chk(pool_free === PWR_ZERO, "pool left unused");
		sink_attached = 2'b00;
		step(6);
		$display("done rebalance");
	endtask : t_rebalance

	// Whole run is a few hundred cycles; this leaves wide margin
	initial begin
		#1000000;
		error_cnt++;
		$display("unexpected at %0t: watchdog", $time);
		results;
	end

	initial begin
		rst = 1'b1;
		group_shared = 1'b0;
		sink_attached = 2'b00;
		port_fault = 2'b00;
		pd_capable = 2'b01;
		yield_ok = 2'b00;
		rebalance_en = 1'b0;
		gotomin_sel = 1'b0;
		legacy_fault = 1'b0;
		want = {PWR_PD_MAX, PWR_PD_MAX};
		slow = 2'b10;
		step(4);
		rst = 1'b0;
		step(4);
		t_legacy;
		t_assured;
		t_shared;
		t_fault;
		t_rebalance;
		results;
	end
endmodule : tb_top

bind charger_budget charger_budget_sva #(.PORT_MAX(PORT_MAX), .BUDGET(BUDGET)) sva_i (
	.clk_sys(clk_sys), .rst(rst), .group_shared(group_shared),
	.sink_attached(sink_attached), .port_fault(port_fault), .pd_capable(pd_capable),
	.yield_ok(yield_ok), .rebalance_en(rebalance_en), .gotomin_sel(gotomin_sel),
	.legacy_fault(legacy_fault), .vbus_en(vbus_en), .adv_level(adv_level),
	.port_offer(port_offer), .caps_send(caps_send), .gotomin_send(gotomin_send),
	.idle_offer(idle_offer), .pool_free(pool_free), .legacy_vbus_en(legacy_vbus_en));

`default_nettype wire
